/* rtl/srs_top.v */
/*
 * Speed reference selector: decodes eight multi-function digital terminals
 * into run, jog, preset, UP/DOWN and auxiliary commands and ramps the output.
 * Assumes analog inputs and motor_running come from logic on sys_clk, and the
 * terminal inputs are asynchronous contact levels.
 */
// What this block does
// - Codes 00/01 give forward/reverse two-wire run.
// - Codes 02-05 preset bits, 29 jog select.
// - Preset bits form binary index 0 to 15.
// - Jog select wins and ignores preset bits.
// - Index 0: preset 0 or analog input.
// - Index 1: auxiliary analog or preset 1.
// - Enabled PID blocks the code 16 switch.
// - Modes 3/4 with code 51 select positions.
// - Codes 06/07 jog forward/reverse at jog frequency.
// - Jog command overrides every other reference.
// - Jog over 500 ms ends with stop mode.
// - Codes 08/09 act only with source 2.
// - UP/DOWN changes only while motor runs.
// - Output ramps at acceleration/deceleration steps.
// - Only UP or only DOWN flags error.
// - UP or DOWN with hold flags error.
// - Code 66 disables PID, holds integral.
// - Code 67 in V/F: analog or pulse generator.
// - Codes 68/69 raise fault 2, overload.
// - UP/DOWN frequency clamped to limits.
// - Hold freezes the ramp at present value.
`timescale 1ns/100ps
`include "srs_map.vh"

module srs_top #(
	parameter TICK_CYC = `SRS_TICK_CYC
) (
	input  wire        sys_clk,             // System clock, 250 MHz.
	input  wire        arst_n,              // Asynchronous reset, active low.
	input  wire [7:0]  term_in,             // Digital input terminals, high = on.
	input  wire [15:0] primary_analog_input,   // First analog reference.
	input  wire [15:0] secondary_analog_input, // Second analog reference.
	input  wire [15:0] aux_analog_freq,     // Auxiliary analog frequency.
	input  wire        motor_running,       // Motor is running.
	input  wire [7:0]  bus_addr,            // Register index.
	input  wire [15:0] bus_wdata,           // Write data.
	input  wire        bus_wr,              // Write strobe.
	input  wire        bus_rd,              // Read strobe.
	output wire [15:0] bus_rdata,           // Read data, cycle after strobe.
	output wire        run_fwd,             // Forward run command.
	output wire        run_rev,             // Reverse run command.
	output wire        jog_run,             // Jog command active.
	output wire [15:0] freq_ref,            // Selected frequency reference.
	output wire [15:0] freq_out,            // Ramped output frequency.
	output wire [3:0]  ref_index,           // Preset or position index.
	output wire        pos_mode,            // Index selects positions.
	output wire        jog_stop_apply,      // Pulse: use stop mode at jog end.
	output wire [1:0]  stop_mode_sel,       // Stop mode to apply.
	output wire        updown_active,       // UP/DOWN reference in use.
	output wire        input_config_error,  // Terminal configuration error.
	output wire        pid_disable,         // PID control disabled.
	output wire        pid_hold_integral,   // Keep last integral value.
	output wire        hand_pulse_generator,// Pulse generator mode.
	output wire        ext_fault2,          // External fault 2 alarm.
	output wire        ext_overload         // External overload input.
);

	// ==========================================================
	// Declarations
	reg  [7:0]  func_r [0:7];
	reg  [15:0] preset_r [0:15];
	reg  [1:0]  freq_src_r;
	reg  [1:0]  run_src_r;
	reg  [7:0]  aux_func_r;
	reg  [2:0]  ctrl_mode_r;
	reg         pid_en_r;
	reg  [1:0]  stop_mode_r;
	reg  [15:0] upper_r;
	reg  [15:0] lower_r;
	reg  [15:0] acc_r;
	reg  [15:0] dec_r;
	reg  [15:0] jog_freq_r;
	reg         ai_sel_r;
	reg  [15:0] rdata_r;
	reg  [15:0] rdata_nxt;
	reg  [17:0] div_r;
	reg         tick_r;
	reg  [9:0]  jog_cnt_r;
	reg         jog_q_r;
	reg         run_q_r;
	reg  [15:0] ud_freq_r;
	reg  [15:0] freq_out_r;
	reg  [15:0] freq_ref_r;
	reg  [15:0] sel_nxt;
	reg  [3:0]  idx_r;
	reg         run_fwd_r, run_rev_r, jog_run_r, pos_mode_r, jog_stop_r;
	reg  [1:0]  stop_sel_r;
	reg         ud_act_r, err_r, pid_dis_r, pid_hold_r, hpg_r, ef2_r, eol_r;
	reg         fwd, rev, jogf, jogr, up, down, hold, pid16, jsel, pos51;
	reg         pid66, hpg_on, hpg_asg, ef2, eol, up_asg, dn_asg;
	reg  [3:0]  ms;
	wire [7:0]  term_s;
	wire        jog_cmd;
	wire        ud_mode;
	wire [16:0] ud_up_sum;
	wire [16:0] out_up_sum;
	integer     i;

	localparam [9:0]  JOG_LONG = `SRS_JOG_LONG_TICKS;
	localparam [17:0] TICK_MAX = TICK_CYC - 1;

	// ==========================================================
	// Terminal synchronisation
	// synchronise all terminals
	srs_sync #(
		.WIDTH (8)
	) u_sync (
		.sys_clk (sys_clk),
		.arst_n  (arst_n),
		.d_in    (term_in),
		.q_out   (term_s)
	);

	// ==========================================================
	// Register writes
	// Indices outside the map are ignored on write.
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (i = 0; i < 8; i = i + 1) begin
				func_r[i] <= `SRS_RST_FUNC;
			end
			for (i = 0; i < 16; i = i + 1) begin
				preset_r[i] <= 16'h0000;
			end
			freq_src_r  <= `SRS_SRC_KEYPAD;
			run_src_r   <= 2'h0;
			aux_func_r  <= 8'h00;
			ctrl_mode_r <= `SRS_MODE_VF;
			pid_en_r    <= 1'b0;
			stop_mode_r <= 2'h0;
			upper_r     <= `SRS_RST_UPPER;
			lower_r     <= 16'h0000;
			acc_r       <= `SRS_RST_STEP;
			dec_r       <= `SRS_RST_STEP;
			jog_freq_r  <= 16'h0000;
			ai_sel_r    <= 1'b0;
		end else if (bus_wr) begin
			if (bus_addr < `SRS_REG_FREQ_SRC) begin
				func_r[bus_addr[2:0]] <= bus_wdata[7:0];
			end else if (bus_addr == `SRS_REG_FREQ_SRC) begin
				freq_src_r <= bus_wdata[1:0];
			end else if (bus_addr == `SRS_REG_RUN_SRC) begin
				run_src_r <= bus_wdata[1:0];
			end else if (bus_addr == `SRS_REG_AUX_FUNC) begin
				aux_func_r <= bus_wdata[7:0];
			end else if (bus_addr == `SRS_REG_CTRL_MODE) begin
				ctrl_mode_r <= bus_wdata[2:0];
			end else if (bus_addr == `SRS_REG_PID_EN) begin
				pid_en_r <= bus_wdata[0];
			end else if (bus_addr == `SRS_REG_STOP_MODE) begin
				stop_mode_r <= bus_wdata[1:0];
			end else if (bus_addr == `SRS_REG_UPPER_LIM) begin
				upper_r <= bus_wdata;
			end else if (bus_addr == `SRS_REG_LOWER_LIM) begin
				lower_r <= bus_wdata;
			end else if (bus_addr == `SRS_REG_ACC_STEP) begin
				acc_r <= bus_wdata;
			end else if (bus_addr == `SRS_REG_DEC_STEP) begin
				dec_r <= bus_wdata;
			end else if (bus_addr == `SRS_REG_JOG_FREQ) begin
				jog_freq_r <= bus_wdata;
			end else if (bus_addr == `SRS_REG_AI_SEL) begin
				ai_sel_r <= bus_wdata[0];
			end else if (bus_addr[7:4] == `SRS_REG_PRESET0 >> 4) begin
				preset_r[bus_addr[3:0]] <= bus_wdata;
			end
		end
	end

	// ==========================================================
	// Register reads
	// Unmapped indices read as zero.
	always @* begin
		rdata_nxt = 16'h0000;
		if (bus_addr < `SRS_REG_FREQ_SRC) begin
			rdata_nxt = {8'h00, func_r[bus_addr[2:0]]};
		end else if (bus_addr == `SRS_REG_FREQ_SRC) begin
			rdata_nxt = {14'h0000, freq_src_r};
		end else if (bus_addr == `SRS_REG_RUN_SRC) begin
			rdata_nxt = {14'h0000, run_src_r};
		end else if (bus_addr == `SRS_REG_AUX_FUNC) begin
			rdata_nxt = {8'h00, aux_func_r};
		end else if (bus_addr == `SRS_REG_CTRL_MODE) begin
			rdata_nxt = {13'h0000, ctrl_mode_r};
		end else if (bus_addr == `SRS_REG_PID_EN) begin
			rdata_nxt = {15'h0000, pid_en_r};
		end else if (bus_addr == `SRS_REG_STOP_MODE) begin
			rdata_nxt = {14'h0000, stop_mode_r};
		end else if (bus_addr == `SRS_REG_UPPER_LIM) begin
			rdata_nxt = upper_r;
		end else if (bus_addr == `SRS_REG_LOWER_LIM) begin
			rdata_nxt = lower_r;
		end else if (bus_addr == `SRS_REG_ACC_STEP) begin
			rdata_nxt = acc_r;
		end else if (bus_addr == `SRS_REG_DEC_STEP) begin
			rdata_nxt = dec_r;
		end else if (bus_addr == `SRS_REG_JOG_FREQ) begin
			rdata_nxt = jog_freq_r;
		end else if (bus_addr == `SRS_REG_STATUS) begin
			rdata_nxt = {idx_r, pos_mode_r, eol_r, ef2_r, hpg_r, pid_hold_r, pid_dis_r,
				err_r, ud_act_r, jog_run_r, run_rev_r, run_fwd_r, 1'b0};
		end else if (bus_addr == `SRS_REG_FREQ_OUT) begin
			rdata_nxt = freq_out_r;
		end else if (bus_addr == `SRS_REG_AI_SEL) begin
			rdata_nxt = {15'h0000, ai_sel_r};
		end else if (bus_addr[7:4] == `SRS_REG_PRESET0 >> 4) begin
			rdata_nxt = preset_r[bus_addr[3:0]];
		end
	end

	// Read data stand in each cycle after a strobe cycle, zero otherwise.
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_r <= 16'h0000;
		end else begin
			rdata_r <= bus_rd ? rdata_nxt : 16'h0000;
		end
	end

	// ==========================================================
	// Terminal function decode
	// Several terminals with one code are ORed; unknown codes do nothing.
	always @* begin
		fwd = 1'b0; rev = 1'b0; jogf = 1'b0; jogr = 1'b0; up = 1'b0; down = 1'b0;
		hold = 1'b0; pid16 = 1'b0; jsel = 1'b0; pos51 = 1'b0; pid66 = 1'b0;
		hpg_on = 1'b0; hpg_asg = 1'b0; ef2 = 1'b0; eol = 1'b0;
		up_asg = 1'b0; dn_asg = 1'b0; ms = 4'h0;
		for (i = 0; i < 8; i = i + 1) begin
			case (func_r[i])
			`SRS_FN_FWD:        fwd = fwd | term_s[i];
			`SRS_FN_REV:        rev = rev | term_s[i];
			`SRS_FN_MS1:        ms[0] = ms[0] | term_s[i];
			`SRS_FN_MS2:        ms[1] = ms[1] | term_s[i];
			`SRS_FN_MS3:        ms[2] = ms[2] | term_s[i];
			`SRS_FN_MS4:        ms[3] = ms[3] | term_s[i];
			`SRS_FN_JOG_SEL:    jsel = jsel | term_s[i];
			`SRS_FN_JOG_FWD:    jogf = jogf | term_s[i];
			`SRS_FN_JOG_REV:    jogr = jogr | term_s[i];
			`SRS_FN_UP: begin
				up     = up | term_s[i];
				up_asg = 1'b1;
			end
			`SRS_FN_DOWN: begin
				down   = down | term_s[i];
				dn_asg = 1'b1;
			end
			`SRS_FN_HOLD:       hold = hold | term_s[i];
			`SRS_FN_PID_DIS:    pid16 = pid16 | term_s[i];
			`SRS_FN_POS_SW:     pos51 = pos51 | term_s[i];
			`SRS_FN_PID_DIS2:   pid66 = pid66 | term_s[i];
			`SRS_FN_PULSE_GEN: begin
				hpg_on  = hpg_on | term_s[i];
				hpg_asg = 1'b1;
			end
			`SRS_FN_EXT_FAULT2: ef2 = ef2 | term_s[i];
			`SRS_FN_EXT_OVLD:   eol = eol | term_s[i];
			default: begin
			end
			endcase
		end
	end

	assign jog_cmd = jogf | jogr;
	// relies on run source and both terminals
	assign ud_mode = (freq_src_r == `SRS_SRC_UPDOWN) && (run_src_r == `SRS_RUN_TERMINAL)
		&& up_asg && dn_asg;

	// ==========================================================
	// Reference selection
	// Later assignments win, so the order below is the priority.
	always @* begin
		sel_nxt = preset_r[ms];
		if (ms == 4'h0) begin
			if (freq_src_r == `SRS_SRC_KEYPAD) begin
				sel_nxt = preset_r[0];
			end else begin
				sel_nxt = ai_sel_r ? secondary_analog_input : primary_analog_input;
			end
		end
		if (ms == 4'h1) begin
			sel_nxt = (aux_func_r == 8'h00) ? aux_analog_freq : preset_r[1];
		end
		if (jsel) begin
			sel_nxt = jog_freq_r;
		end
		if (ud_mode) begin
			sel_nxt = ud_freq_r;
		end
		if (hpg_asg && hpg_on && ctrl_mode_r == `SRS_MODE_VF) begin
			sel_nxt = primary_analog_input;
		end
		if (jog_cmd) begin
			sel_nxt = jog_freq_r;
		end
	end

	// ==========================================================
	// Millisecond tick divider
	// The tick paces ramps and the jog timer; a wide count keeps rates readable.
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			div_r  <= 18'h00000;
			tick_r <= 1'b0;
		end else if (div_r == TICK_MAX) begin
			div_r  <= 18'h00000;
			tick_r <= 1'b1;
		end else begin
			div_r  <= div_r + 18'h00001;
			tick_r <= 1'b0;
		end
	end

	// ==========================================================
	// Jog duration timer
	// Saturates just past the threshold so long jogs never wrap back.
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			jog_cnt_r  <= 10'h000;
			jog_q_r    <= 1'b0;
			jog_stop_r <= 1'b0;
			stop_sel_r <= 2'h0;
		end else begin
			jog_q_r <= jog_cmd;
			jog_stop_r <= jog_q_r && !jog_cmd && (jog_cnt_r > JOG_LONG);
			stop_sel_r <= stop_mode_r;
			if (!jog_cmd) begin
				jog_cnt_r <= 10'h000;
			end else if (tick_r && jog_cnt_r <= JOG_LONG) begin
				jog_cnt_r <= jog_cnt_r + 10'h001;
			end
		end
	end

	// ==========================================================
	// UP/DOWN frequency and output ramp
	assign ud_up_sum  = {1'b0, ud_freq_r} + {1'b0, acc_r};
	assign out_up_sum = {1'b0, freq_out_r} + {1'b0, acc_r};

	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			run_q_r    <= 1'b0;
			ud_freq_r  <= 16'h0000;
			freq_out_r <= 16'h0000;
		end else begin
			run_q_r <= motor_running;
			if (motor_running && !run_q_r) begin
				ud_freq_r <= lower_r;
			end else if (tick_r && motor_running && ud_mode && !hold) begin
				if (up && !down) begin
					ud_freq_r <= (ud_up_sum > {1'b0, upper_r}) ? upper_r : ud_up_sum[15:0];
				end else if (down && !up) begin
					ud_freq_r <= (ud_freq_r < lower_r + dec_r) ? lower_r : ud_freq_r - dec_r;
				end
			end
			if (tick_r && !hold) begin
				if (freq_out_r < freq_ref_r) begin
					freq_out_r <= (out_up_sum > {1'b0, freq_ref_r}) ? freq_ref_r
						: out_up_sum[15:0];
				end else if (freq_out_r > freq_ref_r) begin
					freq_out_r <= (freq_out_r < freq_ref_r + dec_r) ? freq_ref_r
						: freq_out_r - dec_r;
				end
			end
		end
	end

	// ==========================================================
	// Registered command outputs
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			run_fwd_r  <= 1'b0;
			run_rev_r  <= 1'b0;
			jog_run_r  <= 1'b0;
			freq_ref_r <= 16'h0000;
			idx_r      <= 4'h0;
			pos_mode_r <= 1'b0;
			ud_act_r   <= 1'b0;
			err_r      <= 1'b0;
			pid_dis_r  <= 1'b0;
			pid_hold_r <= 1'b0;
			hpg_r      <= 1'b0;
			ef2_r      <= 1'b0;
			eol_r      <= 1'b0;
		end else begin
			run_fwd_r  <= fwd | jogf;
			run_rev_r  <= rev | jogr;
			jog_run_r  <= jog_cmd;
			freq_ref_r <= (fwd | rev | jog_cmd) ? sel_nxt : 16'h0000;
			idx_r      <= jsel ? 4'h0 : ms;
			pos_mode_r <= pos51 && (ctrl_mode_r == `SRS_MODE_SV || ctrl_mode_r == `SRS_MODE_MAGNET_MOTOR_SENSOR_VECTOR);
			ud_act_r   <= ud_mode;
			err_r      <= (up_asg ^ dn_asg) | ((up | down) & hold);
			pid_dis_r  <= (pid16 & ~pid_en_r) | pid66;
			pid_hold_r <= pid66;
			hpg_r      <= hpg_asg && !hpg_on && ctrl_mode_r == `SRS_MODE_VF;
			ef2_r      <= ef2;
			eol_r      <= eol;
		end
	end

	assign bus_rdata = rdata_r;
	assign run_fwd = run_fwd_r;
	assign run_rev = run_rev_r;
	assign jog_run = jog_run_r;
	assign freq_ref = freq_ref_r;
	assign freq_out = freq_out_r;
	assign ref_index = idx_r;
	assign pos_mode = pos_mode_r;
	assign jog_stop_apply = jog_stop_r;
	assign stop_mode_sel = stop_sel_r;
	assign updown_active = ud_act_r;
	assign input_config_error = err_r;
	assign pid_disable = pid_dis_r;
	assign pid_hold_integral = pid_hold_r;
	assign hand_pulse_generator = hpg_r;
	assign ext_fault2 = ef2_r;
	assign ext_overload = eol_r;

endmodule

/* rtl/srs_map.vh */
/*
 * Constants for the speed reference selector: register indices, reset
 * values, terminal function codes and timing counts.
 * Assumes it is included by its bare name by the design files and the bench.
 */
`ifndef SRS_MAP_VH
`define SRS_MAP_VH

// ==========================================================
// Clock and timing
`define SRS_CLK_MHZ 250
`define SRS_TICK_MS 1
`define SRS_TICK_CYC (`SRS_TICK_MS * 1000 * `SRS_CLK_MHZ)
`define SRS_JOG_LONG_MS 500
`define SRS_JOG_LONG_TICKS (`SRS_JOG_LONG_MS / `SRS_TICK_MS)

// ==========================================================
// Register indices on the plain register port
`define SRS_REG_FUNC0 8'h00
`define SRS_REG_FREQ_SRC 8'h08
`define SRS_REG_RUN_SRC 8'h09
`define SRS_REG_AUX_FUNC 8'h0A
`define SRS_REG_CTRL_MODE 8'h0B
`define SRS_REG_PID_EN 8'h0C
`define SRS_REG_STOP_MODE 8'h0D
`define SRS_REG_UPPER_LIM 8'h0E
`define SRS_REG_LOWER_LIM 8'h0F
`define SRS_REG_ACC_STEP 8'h10
`define SRS_REG_DEC_STEP 8'h11
`define SRS_REG_JOG_FREQ 8'h12
`define SRS_REG_STATUS 8'h13
`define SRS_REG_FREQ_OUT 8'h14
`define SRS_REG_AI_SEL 8'h15
`define SRS_REG_PRESET0 8'h20

// ==========================================================
// Reset values
`define SRS_RST_FUNC 8'hFF
`define SRS_RST_UPPER 16'hFFFF
`define SRS_RST_STEP 16'h0001

// ==========================================================
// Setting values
`define SRS_SRC_KEYPAD 2'h0
`define SRS_SRC_TERMINAL 2'h1
`define SRS_SRC_UPDOWN 2'h2
`define SRS_RUN_TERMINAL 2'h1
`define SRS_MODE_VF 3'h0
`define SRS_MODE_SV 3'h3
`define SRS_MODE_MAGNET_MOTOR_SENSOR_VECTOR 3'h4

// ==========================================================
// Terminal function codes
`define SRS_FN_FWD 8'h00
`define SRS_FN_REV 8'h01
`define SRS_FN_MS1 8'h02
`define SRS_FN_MS2 8'h03
`define SRS_FN_MS3 8'h04
`define SRS_FN_MS4 8'h05
`define SRS_FN_JOG_FWD 8'h06
`define SRS_FN_JOG_REV 8'h07
`define SRS_FN_UP 8'h08
`define SRS_FN_DOWN 8'h09
`define SRS_FN_HOLD 8'h0B
`define SRS_FN_PID_DIS 8'h10
`define SRS_FN_JOG_SEL 8'h1D
`define SRS_FN_POS_SW 8'h33
`define SRS_FN_PID_DIS2 8'h42
`define SRS_FN_PULSE_GEN 8'h43
`define SRS_FN_EXT_FAULT2 8'h44
`define SRS_FN_EXT_OVLD 8'h45

`endif

/* rtl/srs_sync.v */
/*
 * Two-stage synchroniser for a group of asynchronous level inputs.
 * Assumes the inputs are slow contact levels; no pulse is preserved.
 */
`timescale 1ns/100ps

module srs_sync #(
	parameter WIDTH = 8
) (
	input  wire             sys_clk,  // System clock.
	input  wire             arst_n,   // Asynchronous reset, active low.
	input  wire [WIDTH-1:0] d_in,     // Asynchronous levels.
	output wire [WIDTH-1:0] q_out     // Synchronised levels.
);

	reg [WIDTH-1:0] meta_r;
	reg [WIDTH-1:0] sync_r;

	// ==========================================================
	// Synchroniser chain
	// The first stage feeds only the second, so a metastable level never spreads.
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_r <= {WIDTH{1'b0}};
			sync_r <= {WIDTH{1'b0}};
		end else begin
			meta_r <= d_in;
			sync_r <= meta_r;
		end
	end

	assign q_out = sync_r;

endmodule

/* sim/srs_contacts.sv */
/*
 * Contact model for the eight digital input terminals of the selector.
 * Assumes the bench sets the wanted contact pattern on press.
 */
`timescale 1ns/100ps

module srs_contacts (
	input  wire       sys_clk, // Clock that times the closures.
	input  wire [7:0] press,   // Wanted contact state, high = closed.
	output reg  [7:0] term_in  // Contact levels at the terminals.
);
	// ==========================================================
	// Contacts
	// A contact moves a cycle after its command; real switches are slower still.
	initial term_in = 8'h00;
	always @(posedge sys_clk) begin
		term_in <= press;
	end
endmodule

/* sim/srs_assertions.sv */
/*
 * Checker for the speed reference selector, relating its output ports.
 * Assumes it is bound to srs_top and sees only that module's ports.
 */
`timescale 1ns/100ps

module srs_chk (
	input wire        sys_clk, // Clock.
	input wire        arst_n, // Reset, active low.
	input wire [7:0]  term_in, // Terminals.
	input wire [7:0]  bus_addr, // Register index.
	input wire [15:0] bus_wdata, // Write data.
	input wire        bus_wr, // Write strobe.
	input wire        run_fwd, // Forward run.
	input wire        run_rev, // Reverse run.
	input wire        jog_run, // Jog active.
	input wire [15:0] freq_ref, // Reference.
	input wire [15:0] freq_out, // Ramped output.
	input wire [3:0]  ref_index, // Index.
	input wire        jog_stop_apply, // Stop mode pulse.
	input wire [1:0]  stop_mode_sel, // Stop mode.
	input wire        ext_fault2, // Fault 2.
	input wire        pid_disable, // PID off.
	input wire        pid_hold_integral // Integral held.
);
	reg [15:0] jog_q;
	reg [15:0] acc_q;
	reg [1:0]  stop_q;

	// ==========================================================
	// Shadow registers
	// Only the settings that the relations below need are tracked here.
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			jog_q  <= 16'h0000;
			acc_q  <= 16'h0001;
			stop_q <= 2'h0;
		end else if (bus_wr) begin
			if (bus_addr == 8'h12) jog_q <= bus_wdata;
			if (bus_addr == 8'h10) acc_q <= bus_wdata;
			if (bus_addr == 8'h0D) stop_q <= bus_wdata[1:0];
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	// Settled inputs must give settled levels; four edges cover sync and decode.
	sequence s_quiet;
		($stable(term_in) && !bus_wr) [*4];
	endsequence

	a_jog_ref_wins: assert property (jog_run && $stable(jog_q) |-> freq_ref == jog_q)
		else $error("jog reference not selected");
	a_jog_runs_motor: assert property (jog_run |-> run_fwd || run_rev)
		else $error("jog without run direction");
	a_idle_ref_zero: assert property (!(run_fwd || run_rev || jog_run) |-> freq_ref == 16'h0000)
		else $error("reference without run command");
	a_stop_after_jog: assert property (jog_stop_apply |-> !jog_run && $past(jog_run))
		else $error("stop mode pulse not at jog end");
	a_stop_one_cycle: assert property (jog_stop_apply |=> !jog_stop_apply)
		else $error("stop mode pulse too long");
	a_stop_mode_copy: assert property (stop_mode_sel == $past(stop_q))
		else $error("stop mode output differs from setting");
	a_pid_hold_off: assert property (pid_hold_integral |-> pid_disable)
		else $error("integral held with PID enabled");
	a_ramp_step_max: assert property (freq_out > $past(freq_out)
		|-> freq_out - $past(freq_out) <= $past(acc_q))
		else $error("ramp step above acceleration step");
	a_sync_stable: assert property (s_quiet |-> $stable({run_fwd, run_rev, jog_run,
		ref_index, ext_fault2, pid_disable}))
		else $error("decoded level moved with quiet inputs");
endmodule

bind srs_top srs_chk u_srs_chk (.sys_clk(sys_clk), .arst_n(arst_n),
	.term_in(term_in), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
	.run_fwd(run_fwd), .run_rev(run_rev), .jog_run(jog_run), .freq_ref(freq_ref),
	.freq_out(freq_out), .ref_index(ref_index), .jog_stop_apply(jog_stop_apply),
	.stop_mode_sel(stop_mode_sel), .ext_fault2(ext_fault2), .pid_disable(pid_disable),
	.pid_hold_integral(pid_hold_integral));

/* sim/tb_top.sv */
/*
 * Self-checking bench for the speed reference selector.
 * Assumes srs_top, srs_contacts and the checker are compiled with it.
 */
`timescale 1ns/100ps
`include "srs_map.vh"

module tb_top;
	reg         sys_clk = 1'b0;
	reg         arst_n = 1'b0;
	reg  [7:0]  press = 8'h00;
	reg  [15:0] ain_a = 16'h0A11, ain_b = 16'h0A22, ain_aux = 16'h0A33;
	reg         motor_running = 1'b0;
	reg  [7:0]  bus_addr = 8'h00;
	reg  [15:0] bus_wdata = 16'h0000;
	reg         bus_wr = 1'b0, bus_rd = 1'b0;
	wire [7:0]  term_in;
	wire [15:0] bus_rdata, freq_ref, freq_out;
	wire [3:0]  ref_index;
	wire [1:0]  stop_mode_sel;
	wire        run_fwd, run_rev, jog_run, pos_mode, jog_stop_apply, updown_active;
	wire        input_config_error, pid_disable, pid_hold_integral, hand_pulse_generator;
	wire        ext_fault2, ext_overload;
	integer     err_total = 0, tests_run = 0, pulses = 0, i;

	// ==========================================================
	// Clock, contacts and design
	initial forever #2 sys_clk = ~sys_clk;
	srs_contacts u_srs_contacts (.sys_clk(sys_clk), .press(press), .term_in(term_in));
	srs_top #(.TICK_CYC(10)) u_srs_top (.sys_clk(sys_clk), .arst_n(arst_n), .term_in(term_in),
		.primary_analog_input(ain_a), .secondary_analog_input(ain_b), .aux_analog_freq(ain_aux),
		.motor_running(motor_running), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .run_fwd(run_fwd),
		.run_rev(run_rev), .jog_run(jog_run), .freq_ref(freq_ref), .freq_out(freq_out),
		.ref_index(ref_index), .pos_mode(pos_mode), .jog_stop_apply(jog_stop_apply),
		.stop_mode_sel(stop_mode_sel), .updown_active(updown_active),
		.input_config_error(input_config_error), .pid_disable(pid_disable),
		.pid_hold_integral(pid_hold_integral), .hand_pulse_generator(hand_pulse_generator),
		.ext_fault2(ext_fault2), .ext_overload(ext_overload));

	// Pulses are counted so a missed or doubled stop pulse shows in one compare.
	always @(posedge sys_clk) begin
		if (jog_stop_apply === 1'b1) pulses = pulses + 1;
	end

	// ==========================================================
	// Tasks
	task chk(input [15:0] got, input [15:0] exp);
		begin
			tests_run = tests_run + 1;
			if (got !== exp) begin
				err_total = err_total + 1;
				$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task chkb(input got, input exp);
		begin
			chk({15'h0000, got}, {15'h0000, exp});
		end
	endtask
	task wr(input [7:0] a, input [15:0] d);
		begin
			@(posedge sys_clk);
			bus_wr <= 1'b1;
			bus_addr <= a;
			bus_wdata <= d;
			@(posedge sys_clk);
			bus_wr <= 1'b0;
		end
	endtask
	task fn(input [7:0] slot, input [7:0] code);
		begin
			wr(slot, {8'h00, code});
		end
	endtask
	task rd(input [7:0] a, input [15:0] exp);
		begin
			@(posedge sys_clk);
			bus_rd <= 1'b1;
			bus_addr <= a;
			@(posedge sys_clk);
			bus_rd <= 1'b0;
			@(posedge sys_clk);
			chk(bus_rdata, exp);
		end
	endtask
	// Six edges cover the contact, the synchroniser and the decode.
	task push(input [7:0] p);
		begin
			@(posedge sys_clk);
			press <= p;
			repeat (6) @(posedge sys_clk);
		end
	endtask
	task test_done;
		begin
			if (err_total == 0 && tests_run > 0) begin
				$display("== PASSED ==");
			end else begin
				$display("== FAILED ==");
			end
			$finish;
		end
	endtask

	// ==========================================================
	// Watchdog, about three times the expected run.
	initial begin
		#80000;
		err_total = err_total + 1;
		test_done;
	end

	// ==========================================================
	// Main sequence
	initial begin
		repeat (20) @(posedge sys_clk);
		arst_n <= 1'b1;
		rd(`SRS_REG_FUNC0, 16'h00FF);
		rd(`SRS_REG_UPPER_LIM, 16'hFFFF);
		rd(8'h30, 16'h0000);
		for (i = 0; i < 4; i = i + 1) fn(i[7:0], `SRS_FN_MS1 + i[7:0]);
		fn(8'h04, `SRS_FN_JOG_SEL);
		fn(8'h05, `SRS_FN_FWD);
		fn(8'h06, `SRS_FN_JOG_FWD);
		fn(8'h07, `SRS_FN_EXT_FAULT2);
		wr(`SRS_REG_AUX_FUNC, 16'h0001);
		wr(`SRS_REG_JOG_FREQ, 16'h0777);
		wr(`SRS_REG_STOP_MODE, 16'h0002);
		for (i = 0; i < 16; i = i + 1) wr(`SRS_REG_PRESET0 + i[7:0], 16'h0100 + i[15:0]);
		for (i = 0; i < 16; i = i + 1) begin
			push(8'h20 | i[7:0]);
			chk(freq_ref, 16'h0100 + i[15:0]);
			chk({12'h000, ref_index}, i[15:0]);
		end
		push(8'h35);
		chk(freq_ref, 16'h0777);
		chk({12'h000, ref_index}, 16'h0000);
		wr(`SRS_REG_AUX_FUNC, 16'h0000);
		push(8'h21);
		chk(freq_ref, ain_aux);
		wr(`SRS_REG_FREQ_SRC, 16'h0001);
		wr(`SRS_REG_AI_SEL, 16'h0001);
		push(8'h20);
		chk(freq_ref, ain_b);
		push(8'hA3);
		chkb(ext_fault2, 1'b1);
		// Long jog, then a short one; only the long one may pulse.
		push(8'h63);
		chk(freq_ref, 16'h0777);
		chkb(jog_run, 1'b1);
		repeat (5100) @(posedge sys_clk);
		push(8'h23);
		chk(pulses[15:0], 16'h0001);
		chk({14'h0000, stop_mode_sel}, 16'h0002);
		push(8'h63);
		repeat (100) @(posedge sys_clk);
		push(8'h23);
		chk(pulses[15:0], 16'h0001);
		// Auxiliary functions on slots 4 to 7.
		fn(8'h04, `SRS_FN_REV);
		fn(8'h05, `SRS_FN_PID_DIS2);
		fn(8'h06, `SRS_FN_PULSE_GEN);
		fn(8'h07, `SRS_FN_EXT_OVLD);
		push(8'h00);
		chkb(hand_pulse_generator, 1'b1);
		push(8'hF0);
		chkb(run_rev, 1'b1);
		chkb(pid_hold_integral, 1'b1);
		chkb(ext_overload, 1'b1);
		chkb(hand_pulse_generator, 1'b0);
		chk(freq_ref, ain_a);
		fn(8'h05, `SRS_FN_PID_DIS);
		wr(`SRS_REG_PID_EN, 16'h0001);
		push(8'h20);
		chkb(pid_disable, 1'b0);
		fn(8'h06, `SRS_FN_POS_SW);
		wr(`SRS_REG_CTRL_MODE, 16'h0003);
		push(8'h40);
		chkb(pos_mode, 1'b1);
		// UP alone, then UP and DOWN with hold pressed beside UP.
		fn(8'h00, `SRS_FN_UP);
		push(8'h00);
		chkb(input_config_error, 1'b1);
		fn(8'h01, `SRS_FN_DOWN);
		fn(8'h02, `SRS_FN_HOLD);
		fn(8'h03, `SRS_FN_FWD);
		push(8'h00);
		chkb(input_config_error, 1'b0);
		push(8'h05);
		chkb(input_config_error, 1'b1);
		wr(`SRS_REG_FREQ_SRC, 16'h0002);
		wr(`SRS_REG_RUN_SRC, 16'h0001);
		wr(`SRS_REG_LOWER_LIM, 16'h0010);
		wr(`SRS_REG_UPPER_LIM, 16'h0014);
		wr(`SRS_REG_DEC_STEP, 16'h0100);
		motor_running <= 1'b1;
		push(8'h08);
		chk(freq_ref, 16'h0010);
		push(8'h09);
		repeat (100) @(posedge sys_clk);
		chk(freq_ref, 16'h0014);
		chkb(updown_active, 1'b1);
		motor_running <= 1'b0;
		push(8'h0A);
		repeat (100) @(posedge sys_clk);
		chk(freq_ref, 16'h0014);
		repeat (200) @(posedge sys_clk);
		chk(freq_out, 16'h0014);
		push(8'h0C);
		wr(`SRS_REG_FREQ_SRC, 16'h0000);
		repeat (100) @(posedge sys_clk);
		chk(freq_ref, 16'h0100);
		chk(freq_out, 16'h0014);
		rd(`SRS_REG_STATUS, 16'h0002);
		test_done;
	end
endmodule
